// ### hw/dsw_pkg.sv
// Constants and types shared by both ends of the deep sleep wake link
package dsw_pkg;
    // Timing
    localparam int CLK_PERIOD_NS  = 10;
    localparam int MS_NS          = 1000000;
    localparam int CYC_PER_MS     = MS_NS / CLK_PERIOD_NS;
    localparam int LP_WAKE_TICKS  = 2;
    localparam int CLK_DLY_MIN_MS = 3;
    localparam int CLK_DLY_MAX_MS = 39;
    localparam int HOST_XFER_CYC  = 16;
    localparam int HOST_LP_DIV    = 8;

    // Link messages on the serial-peripheral transport
    localparam logic [1:0] MSG_WAKE  = 2'h1;
    localparam logic [1:0] MSG_SLEEP = 2'h2;

    typedef enum logic [1:0] {
        MODE_MSG,
        MODE_PLAIN,
        MODE_HSHAKE
    } dsw_mode_type;

    // Host register map, byte addresses
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_CFG  = 4'h4;
    localparam logic [3:0] REG_STAT = 4'h8;

    // Control bits
    localparam int CTRL_WAKE      = 0;
    localparam int CTRL_CTS_READY = 1;
    localparam int CTRL_XFER      = 2;
    localparam int CTRL_SEND_WAKE = 3;
    localparam int CTRL_SEND_SLP  = 4;
    localparam int CTRL_MSG_MODE  = 5;

    // Status bits
    localparam int STAT_CLK_REQ = 0;
    localparam int STAT_ATTN    = 1;
    localparam int STAT_FLOW    = 2;
    localparam int STAT_AWAKE   = 3;
    localparam int STAT_BUSY    = 4;
    localparam int STAT_CLK_OK  = 5;

    localparam logic [15:0] CFG_RESET = 16'h0010;
endpackage

// ### hw/dsw_link_if.sv
// Pins between the radio controller and its host
`timescale 1ns/100ps
interface dsw_link_if;
    logic       low_power_clock;
    logic       host_wake_in;
    logic       spi_select_n;
    logic       uart_flow_in;
    logic       msg_valid;
    logic [1:0] msg_code;
    logic       sys_clk_request_hi;
    logic       sys_clk_request_lo;
    logic       spi_attention_out;
    logic       host_attention_out;
    logic       uart_flow_out;
    logic       awake_reply_msg;

    modport dev (
        input  low_power_clock, host_wake_in, spi_select_n, uart_flow_in,
        input  msg_valid, msg_code,
        output sys_clk_request_hi, sys_clk_request_lo, spi_attention_out,
        output host_attention_out, uart_flow_out, awake_reply_msg
    );
    modport host (
        output low_power_clock, host_wake_in, spi_select_n, uart_flow_in,
        output msg_valid, msg_code,
        input  sys_clk_request_hi, sys_clk_request_lo, spi_attention_out,
        input  host_attention_out, uart_flow_out, awake_reply_msg
    );
endinterface

// ### hw/dsw_sync.sv
// Two flip-flop level synchroniser
`timescale 1ns/100ps
module dsw_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Level in and out
    input  wire logic d_i,
    output logic      q_o
);
    logic meta_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_r <= 1'b0;
            q_o    <= 1'b0;
        end else begin
            meta_r <= d_i;
            q_o    <= meta_r;
        end
    end
endmodule

// ### hw/dsw_device.sv
// Radio controller end: clock request and deep sleep sequencing
//
// Local design decisions: none here; the Avalon-MM slave port is in dsw_host and the register offsets are in dsw_pkg.
`timescale 1ns/100ps
module dsw_device #(
    parameter int CYC_PER_MS = dsw_pkg::CYC_PER_MS
) (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // Link to host
    dsw_link_if.dev                   link,
    // Configuration
    input  wire dsw_pkg::dsw_mode_type mode_i,
    input  wire logic                 spi_transport_i,
    input  wire logic                 wait_wake_i,
    input  wire logic [5:0]           clk_dly_ms_i,
    // Controller activity
    input  wire logic                 auto_wake_i,
    input  wire logic                 traffic_pending_i,
    input  wire logic                 air_busy_i,
    input  wire logic                 xfer_done_i,
    // Status
    output logic                      sys_clk_on_o,
    output logic                      deep_sleep_o,
    output logic                      wake_irq_o
);
    typedef enum logic [2:0] {
        ST_SLEEP,
        ST_REQ_WAIT,
        ST_CLK_WAIT,
        ST_ACTIVE,
        ST_DRAIN,
        ST_FLOW_OFF,
        ST_RELEASE
    } dsw_state_type;

    dsw_state_type state_r;
    logic          wake_s;
    logic          lpc_s;
    logic          lpc_d_r;
    logic          lp_tick;
    logic [1:0]    tick_cnt_r;
    logic [22:0]   dly_cnt_r;
    logic [22:0]   dly_load;
    logic          req_r;
    logic          auto_r;
    logic          auto_data_r;
    logic          msg_wake_r;
    logic          perm_r;
    logic          att_r;
    logic          flow_r;
    logic          reply_r;
    logic          irq_r;
    logic          is_msg;
    logic          is_hs;
    logic          msg_wake;
    logic          msg_sleep;
    logic          wake_go;
    logic          flow_hold;

    assign is_msg    = (mode_i == dsw_pkg::MODE_MSG);
    assign is_hs     = (mode_i == dsw_pkg::MODE_HSHAKE);
    assign msg_wake  = link.msg_valid && (link.msg_code == dsw_pkg::MSG_WAKE);
    assign msg_sleep = link.msg_valid && (link.msg_code == dsw_pkg::MSG_SLEEP);
    assign wake_go   = is_msg ? msg_wake : wake_s;

    ////////////////////////////////////////////////////////////////////////
    // wake and low-power clock input synchronisers
    dsw_sync u_wake_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (link.host_wake_in),
        .q_o   (wake_s)
    );

    dsw_sync u_lpc_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (link.low_power_clock),
        .q_o   (lpc_s)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lpc_d_r <= 1'b0;
        end else begin
            lpc_d_r <= lpc_s;
        end
    end

    assign lp_tick = lpc_s && !lpc_d_r;

    // delay in cycles from the programmed millisecond count
    assign dly_load = 23'(clk_dly_ms_i < 6'(dsw_pkg::CLK_DLY_MIN_MS)
                      ? dsw_pkg::CLK_DLY_MIN_MS * CYC_PER_MS
                      : clk_dly_ms_i > 6'(dsw_pkg::CLK_DLY_MAX_MS)
                      ? dsw_pkg::CLK_DLY_MAX_MS * CYC_PER_MS
                      : int'(clk_dly_ms_i) * CYC_PER_MS);

    // hold flow off until the host raises wake, if so configured
    assign flow_hold = auto_r && wait_wake_i && !wake_s;

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_r    <= ST_SLEEP;
            tick_cnt_r <= 2'h0;
            dly_cnt_r  <= 23'h0;
            req_r      <= 1'b0;
            auto_r     <= 1'b0;
            auto_data_r <= 1'b0;
            msg_wake_r <= 1'b0;
        end else begin
            case (state_r)
                ST_SLEEP: begin
                    tick_cnt_r <= 2'h0;
                    if (wake_go) begin
                        state_r    <= ST_REQ_WAIT;
                        auto_r     <= 1'b0;
                        msg_wake_r <= is_msg;
                    end else if (auto_wake_i) begin
                        state_r     <= ST_CLK_WAIT;
                        req_r       <= 1'b1;
                        dly_cnt_r   <= dly_load;
                        auto_r      <= 1'b1;
                        auto_data_r <= traffic_pending_i;
                        msg_wake_r  <= 1'b0;
                    end
                end
                ST_REQ_WAIT: begin
                    if (lp_tick) begin
                        tick_cnt_r <= tick_cnt_r + 2'h1;
                        // request high on the second tick
                        if (tick_cnt_r == 2'(dsw_pkg::LP_WAKE_TICKS - 1)) begin
                            state_r   <= ST_CLK_WAIT;
                            req_r     <= 1'b1;
                            dly_cnt_r <= dly_load;
                        end
                    end
                end
                ST_CLK_WAIT: begin
                    // clock assumed stable after the delay
                    if (dly_cnt_r <= 23'h1) begin
                        state_r <= ST_ACTIVE;
                    end else begin
                        dly_cnt_r <= dly_cnt_r - 23'h1;
                    end
                end
                ST_ACTIVE: begin
                    // leave only on permission, once idle
                    if (perm_r && !air_busy_i) begin
                        if (is_hs) begin
                            state_r <= traffic_pending_i ? ST_DRAIN
                                                         : ST_FLOW_OFF;
                        end else if (!traffic_pending_i) begin
                            state_r <= ST_RELEASE;
                        end
                    end
                end
                ST_DRAIN: begin
                    // stay until pending traffic is sent
                    if (!traffic_pending_i) begin
                        state_r <= ST_FLOW_OFF;
                    end
                end
                ST_FLOW_OFF: begin
                    state_r <= ST_RELEASE;
                end
                ST_RELEASE: begin
                    req_r   <= 1'b0;
                    state_r <= ST_SLEEP;
                end
                default: begin
                    state_r <= ST_SLEEP;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sleep permission
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            perm_r <= 1'b0;
        end else if (state_r != ST_ACTIVE) begin
            perm_r <= 1'b0;
        end else if (is_msg) begin
            // only a sleep message; or end of autonomous transfer
            if (msg_sleep || (auto_data_r && xfer_done_i)) begin
                perm_r <= 1'b1;
            end
        end else begin
            // wake low permits, wake high withdraws
            perm_r <= !wake_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Attention line
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            att_r <= 1'b0;
        end else if (is_hs) begin
            // follows pending events, dropped before flow off
            att_r <= (state_r == ST_ACTIVE || state_r == ST_DRAIN)
                     && traffic_pending_i;
        end else if (state_r != ST_ACTIVE) begin
            att_r <= 1'b0;
        end else if (!link.spi_select_n) begin
            att_r <= 1'b0;
        end else if (traffic_pending_i && !(auto_r && !auto_data_r)) begin
            att_r <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Flow control, high means flow off
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flow_r <= 1'b1;
        end else if (!is_hs || spi_transport_i) begin
            flow_r <= 1'b1;
        end else if (state_r == ST_FLOW_OFF) begin
            // flow off before the request falls
            flow_r <= 1'b1;
        end else if (state_r == ST_ACTIVE && flow_r) begin
            // flow on unless held or wake had no traffic
            if (!flow_hold && !(auto_r && !auto_data_r)) begin
                flow_r <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake message reply and internal interrupt
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_r   <= 1'b0;
            reply_r <= 1'b0;
        end else begin
            // decoded while the system clock is still stopped
            irq_r   <= (state_r == ST_SLEEP) && is_msg && msg_wake;
            // awake reply once the clock is in use
            reply_r <= (state_r == ST_CLK_WAIT) && msg_wake_r
                       && (dly_cnt_r <= 23'h1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    // same request at both polarities
    assign link.sys_clk_request_hi = req_r;
    assign link.sys_clk_request_lo = !req_r;
    // handshake attention follows the selected transport
    assign link.host_attention_out = is_hs && !spi_transport_i && att_r;
    assign link.spi_attention_out  = (!is_hs || spi_transport_i) && att_r;
    assign link.uart_flow_out      = flow_r;
    assign link.awake_reply_msg    = reply_r;
    assign sys_clk_on_o = (state_r == ST_ACTIVE) || (state_r == ST_DRAIN)
                          || (state_r == ST_FLOW_OFF);
    assign deep_sleep_o = (state_r == ST_SLEEP);
    assign wake_irq_o   = irq_r;
endmodule

// ### hw/dsw_host.sv
// Host end: wake line, messages, select and flow under register control
`timescale 1ns/100ps
module dsw_host #(
    parameter int XFER_CYC = dsw_pkg::HOST_XFER_CYC,
    parameter int LP_DIV   = dsw_pkg::HOST_LP_DIV
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Avalon-MM slave
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // Link to device
    dsw_link_if.host         link
);
    logic [5:0]  ctrl_r;
    logic [15:0] cfg_r;
    logic        ack_r;
    logic        wr_en;
    logic [15:0] gap_cnt_r;
    logic        clk_ok_r;
    logic        awake_r;
    logic        xfer_pend_r;
    logic [7:0]  xfer_cnt_r;
    logic        busy_r;
    logic        wake_pin_r;
    logic [7:0]  lp_cnt_r;
    logic        lpc_r;
    logic        msg_v_r;
    logic [1:0]  msg_c_r;
    logic        attn;
    logic        start;
    logic [31:0] stat;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait state on every access
    assign waitrequest = (read || write) && !ack_r;
    assign wr_en       = write && ack_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r    <= 1'b0;
            readdata <= 32'h0;
        end else begin
            ack_r <= (read || write) && !ack_r;
            if (read && !ack_r) begin
                case (address)
                    dsw_pkg::REG_CTRL: readdata <= {26'h0, ctrl_r};
                    dsw_pkg::REG_CFG:  readdata <= {16'h0, cfg_r};
                    dsw_pkg::REG_STAT: readdata <= stat;
                    default:           readdata <= 32'h0;
                endcase
            end
        end
    end

    // Pulse bits self-clear on the cycle after they are written
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_r <= 6'h0;
            cfg_r  <= dsw_pkg::CFG_RESET;
        end else begin
            ctrl_r[dsw_pkg::CTRL_XFER]      <= 1'b0;
            ctrl_r[dsw_pkg::CTRL_SEND_WAKE] <= 1'b0;
            ctrl_r[dsw_pkg::CTRL_SEND_SLP]  <= 1'b0;
            if (wr_en && address == dsw_pkg::REG_CTRL) begin
                ctrl_r <= writedata[5:0];
            end
            if (wr_en && address == dsw_pkg::REG_CFG) begin
                cfg_r <= writedata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // minimum gap between request rise and select
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gap_cnt_r <= 16'h0;
            clk_ok_r  <= 1'b0;
        end else if (!link.sys_clk_request_hi) begin
            gap_cnt_r <= 16'h0;
            clk_ok_r  <= 1'b0;
        end else if (gap_cnt_r >= cfg_r) begin
            clk_ok_r <= 1'b1;
        end else begin
            gap_cnt_r <= gap_cnt_r + 16'h1;
        end
    end

    // in message mode no software-requested exchange before the awake reply; attention may start one
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            awake_r <= 1'b0;
        end else if (link.awake_reply_msg) begin
            awake_r <= 1'b1;
        end else if (ctrl_r[dsw_pkg::CTRL_SEND_SLP]
                     || ctrl_r[dsw_pkg::CTRL_SEND_WAKE]) begin
            awake_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transfer: select low for a fixed frame
    assign attn  = link.spi_attention_out || link.host_attention_out;
    // attention or software request starts a frame
    assign start = !busy_r && clk_ok_r && (xfer_pend_r || attn)
                   && (awake_r || !ctrl_r[dsw_pkg::CTRL_MSG_MODE]
                       || attn);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            xfer_pend_r <= 1'b0;
            busy_r      <= 1'b0;
            xfer_cnt_r  <= 8'h0;
        end else begin
            if (ctrl_r[dsw_pkg::CTRL_XFER]) begin
                xfer_pend_r <= 1'b1;
            end else if (start) begin
                xfer_pend_r <= 1'b0;
            end
            if (start) begin
                busy_r     <= 1'b1;
                xfer_cnt_r <= 8'(XFER_CYC - 1);
            end else if (busy_r) begin
                if (xfer_cnt_r == 8'h0) begin
                    busy_r <= 1'b0;
                end else begin
                    xfer_cnt_r <= xfer_cnt_r - 8'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Wake pin, messages and low-power clock
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_pin_r <= 1'b0;
            msg_v_r    <= 1'b0;
            msg_c_r    <= 2'h0;
            lp_cnt_r   <= 8'h0;
            lpc_r      <= 1'b0;
        end else begin
            // wake falls only once no transfer frame is in flight
            if (ctrl_r[dsw_pkg::CTRL_WAKE] || !busy_r) begin
                wake_pin_r <= ctrl_r[dsw_pkg::CTRL_WAKE];
            end
            // messages to the device, wake wins over sleep in the same cycle
            msg_v_r <= ctrl_r[dsw_pkg::CTRL_SEND_WAKE]
                       || ctrl_r[dsw_pkg::CTRL_SEND_SLP];
            msg_c_r <= ctrl_r[dsw_pkg::CTRL_SEND_WAKE] ? dsw_pkg::MSG_WAKE
                                                         : dsw_pkg::MSG_SLEEP;
            if (lp_cnt_r == 8'(LP_DIV - 1)) begin
                lp_cnt_r <= 8'h0;
                lpc_r    <= !lpc_r;
            end else begin
                lp_cnt_r <= lp_cnt_r + 8'h1;
            end
        end
    end

    assign stat = {26'h0, clk_ok_r, busy_r, awake_r, link.uart_flow_out,
                   attn, link.sys_clk_request_hi};

    assign link.low_power_clock = lpc_r;
    assign link.host_wake_in    = wake_pin_r;
    assign link.spi_select_n    = !busy_r;
    // flow in low when host is ready and the device has events
    assign link.uart_flow_in    = !(ctrl_r[dsw_pkg::CTRL_CTS_READY]
                                    && link.host_attention_out);
    assign link.msg_valid       = msg_v_r;
    assign link.msg_code        = msg_c_r;
endmodule

// ### dv/dsw_chk.sv
// Assertions on the link pins between host and device
`timescale 1ns/100ps
module dsw_chk (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Link pins
    input wire logic spi_select_n,
    input wire logic msg_valid,
    input wire logic sys_clk_request_hi,
    input wire logic sys_clk_request_lo,
    input wire logic spi_attention_out,
    input wire logic host_attention_out,
    input wire logic uart_flow_out,
    input wire logic awake_reply_msg
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_req_inverse: assert property (
        sys_clk_request_lo == !sys_clk_request_hi)
        else $error("clock request outputs not inverse");
    a_attn_after_req: assert property (
        host_attention_out || spi_attention_out |-> sys_clk_request_hi)
        else $error("attention without clock request");
    a_flow_off_asleep: assert property (
        !sys_clk_request_hi |-> uart_flow_out)
        else $error("flow on without clock request");
    a_drop_order: assert property (
        $fell(sys_clk_request_hi) |->
        $past(uart_flow_out) && !$past(host_attention_out))
        else $error("request dropped before flow off");
    a_reply_pulse: assert property (
        awake_reply_msg |=> !awake_reply_msg)
        else $error("awake reply longer than a cycle");
    a_reply_req: assert property (
        awake_reply_msg |-> sys_clk_request_hi)
        else $error("awake reply without clock request");
    a_flow_on_req: assert property (
        $fell(uart_flow_out) |-> sys_clk_request_hi)
        else $error("flow on while clock not requested");
    a_select_req: assert property (
        $fell(spi_select_n) |-> sys_clk_request_hi)
        else $error("select while clock not requested");
    a_select_hold: assert property (
        $fell(spi_select_n) |-> !spi_select_n [*8])
        else $error("select frame cut short");
    a_msg_pulse: assert property (
        msg_valid |=> !msg_valid)
        else $error("message strobe longer than a cycle");
endmodule

// ### dv/deep_sleep_wake_handshake_bench.sv
// Self-checking bench: host and device ends joined over the link
`timescale 1ns/100ps
module deep_sleep_wake_handshake_bench;
    // Short millisecond keeps the clock delay run brief
    localparam int CPM = 10;
    logic                  clk_i = 1'b0;
    logic                  rst_i = 1'b1;
    logic [3:0]            address = 4'h0;
    logic                  read = 1'b0;
    logic                  write = 1'b0;
    logic [31:0]           writedata = 32'h0;
    logic [31:0]           readdata;
    logic                  waitrequest;
    dsw_pkg::dsw_mode_type mode = dsw_pkg::MODE_PLAIN;
    logic                  aw = 1'b0;
    logic                  trf = 1'b0;
    logic                  air = 1'b0;
    logic                  xd = 1'b0;
    logic [5:0]            dly = 6'h03;
    logic                  sp = 1'b0;
    logic                  ww = 1'b0;
    logic [15:0]           cfg_m = dsw_pkg::CFG_RESET;
    logic                  con, slp, irq;
    logic [31:0]           q;
    int                    num_errors = 0;
    int                    n_tests = 0;
    int                    n, r, e;
    dsw_link_if link ();
    always #5 clk_i = ~clk_i;
    dsw_host i_dsw_host (.clk_i, .rst_i, .address, .read, .write,
        .writedata, .readdata, .waitrequest, .link);
    dsw_device #(.CYC_PER_MS(CPM)) i_dsw_device (.clk_i, .rst_i,
        .link, .mode_i(mode), .spi_transport_i(sp),
        .wait_wake_i(ww), .clk_dly_ms_i(dly), .auto_wake_i(aw),
        .traffic_pending_i(trf), .air_busy_i(air), .xfer_done_i(xd),
        .sys_clk_on_o(con), .deep_sleep_o(slp), .wake_irq_o(irq));
    dsw_chk i_dsw_chk (.clk_i, .rst_i,
        .spi_select_n(link.spi_select_n), .msg_valid(link.msg_valid),
        .sys_clk_request_hi(link.sys_clk_request_hi),
        .sys_clk_request_lo(link.sys_clk_request_lo),
        .spi_attention_out(link.spi_attention_out),
        .host_attention_out(link.host_attention_out),
        .uart_flow_out(link.uart_flow_out),
        .awake_reply_msg(link.awake_reply_msg));
    ////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic ck(input logic ok, input string m);
        n_tests++;
        if (ok !== 1'b1) begin
            $display("wrong value at %0t: %s", $time, m);
            num_errors++;
        end
    endtask
    // Ready is sampled at the rising edge; read data are taken there too
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge clk_i);
        address <= a;
        writedata <= d;
        write <= w;
        read <= !w;
        if (w && a == dsw_pkg::REG_CFG) begin
            cfg_m = d[15:0];
        end
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (n > 50) begin num_errors++; stop_test(); end
        end while (waitrequest !== 1'b0);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask
    function automatic logic pick(input int s);
        case (s)
            0: return link.sys_clk_request_hi;
            1: return con;
            2: return slp;
            3: return irq;
            4: return link.uart_flow_out;
            5: return link.host_attention_out;
            default: return link.spi_attention_out;
        endcase
    endfunction
    task automatic wt(input int s, input logic v);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (n > 9000) begin num_errors++; stop_test(); end
        end while (pick(s) !== v);
    endtask
    task automatic rst5;
        @(posedge clk_i);
        rst_i <= 1'b1;
        cfg_m = dsw_pkg::CFG_RESET;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(42));
        rst5();
        @(posedge clk_i);
        ck(link.sys_clk_request_lo === 1'b1 && slp === 1'b1, "reset");
        bus(0, dsw_pkg::REG_CFG, 0);
        ck(q[15:0] === dsw_pkg::CFG_RESET, "cfg reset value");
        bus(0, 4'hC, 0);
        ck(q === 32'h0, "unmapped read");
        bus(1, dsw_pkg::REG_CFG, 32'h4);
        bus(0, dsw_pkg::REG_CFG, 0);
        ck(q[15:0] === cfg_m, "cfg readback");
        r = $urandom_range(63);
        dly <= 6'(r);
        bus(1, dsw_pkg::REG_CTRL, 32'h1);
        wt(0, 1'b1);
        ck(n >= 16 && n <= 56, "wake to request");
        wt(1, 1'b1);
        e = r < 3 ? 3 : (r > 39 ? 39 : r);
        ck(n >= e * CPM && n <= e * CPM + 4, "clock delay");
        air <= 1'b1;
        bus(1, dsw_pkg::REG_CTRL, 32'h0);
        repeat (30) @(posedge clk_i);
        ck(link.sys_clk_request_hi === 1'b1, "slept while busy");
        air <= 1'b0;
        wt(2, 1'b1);
        ck(link.sys_clk_request_hi === 1'b0, "sleep entry");
        mode <= dsw_pkg::MODE_HSHAKE;
        trf <= 1'b1;
        bus(1, dsw_pkg::REG_CTRL, 32'h3);
        wt(4, 1'b0);
        ck(con === 1'b1, "flow on before clock");
        wt(5, 1'b1);
        bus(1, dsw_pkg::REG_CTRL, 32'h2);
        repeat (30) @(posedge clk_i);
        ck(link.host_attention_out === 1'b1 && !slp, "drain");
        trf <= 1'b0;
        wt(0, 1'b0);
        ck(link.uart_flow_out === 1'b1, "entry order");
        wt(2, 1'b1);
        aw <= 1'b1;
        wt(0, 1'b1);
        ck(n <= 3, "autonomous request");
        aw <= 1'b0;
        wt(1, 1'b1);
        @(posedge clk_i);
        ck(link.uart_flow_out === 1'b1 && !pick(5), "quiet wake");
        wt(2, 1'b1);
        ww <= 1'b1;
        air <= 1'b1;
        trf <= 1'b1;
        aw <= 1'b1;
        wt(5, 1'b1);
        ck(link.uart_flow_out === 1'b1, "flow held for wake");
        aw <= 1'b0;
        bus(1, dsw_pkg::REG_CTRL, 32'h3);
        wt(4, 1'b0);
        sp <= 1'b1;
        repeat (2) @(posedge clk_i);
        ck(pick(6) && !pick(5) && pick(4), "spi transport");
        mode <= dsw_pkg::MODE_MSG;
        sp <= 1'b0;
        ww <= 1'b0;
        air <= 1'b0;
        trf <= 1'b0;
        rst5();
        bus(1, dsw_pkg::REG_CTRL, 32'h28);
        wt(3, 1'b1);
        ck(con === 1'b0 && link.sys_clk_request_hi === 1'b0,
           "wake decode asleep");
        wt(1, 1'b1);
        bus(0, dsw_pkg::REG_STAT, 0);
        ck(q[dsw_pkg::STAT_AWAKE] === 1'b1, "awake reply");
        bus(1, dsw_pkg::REG_CTRL, 32'h30);
        wt(2, 1'b1);
        ck(link.sys_clk_request_lo === 1'b1, "sleep message");
        trf <= 1'b1;
        aw <= 1'b1;
        wt(6, 1'b1);
        ck(link.sys_clk_request_hi === 1'b1, "request first");
        aw <= 1'b0;
        bus(1, dsw_pkg::REG_CTRL, 32'h24);
        wt(6, 1'b0);
        trf <= 1'b0;
        xd <= 1'b1;
        @(posedge clk_i);
        xd <= 1'b0;
        wt(2, 1'b1);
        ck(link.sys_clk_request_hi === 1'b0, "sleep after xfer");
        stop_test();
    end
endmodule
